// file: flash_bus_cycle.sv
`timescale 1ns/100ps
`include "flash_poll_params.svh"
module flash_bus_cycle #(
  parameter int STROBE = `STROBE_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  dq_sync_i,
  output logic             done_o,
  output logic [7:0]       rdata_o,
  output logic [16:0]      fl_addr_o,
  output logic [7:0]       fl_dq_o,
  output logic             fl_dq_oe_o,
  output logic             fl_ce_n_o,
  output logic             fl_oe_n_o,
  output logic             fl_we_n_o
);
  // strobe phase, then three cycles for synchronised data to settle and be returned
  localparam int TOTAL = STROBE + 3;
  logic [7:0] cnt;
  logic       busy;
  logic       is_wr;
  wire        strobe_on = busy && (cnt < 8'(STROBE));
  wire        last      = busy && (cnt == 8'(TOTAL - 1));
  wire        sample    = busy && (cnt == 8'(TOTAL - 2));
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      is_wr <= 1'b0;
      fl_addr_o <= 17'h0_0000;
      fl_dq_o <= 8'h00;
      rdata_o <= 8'h00;
    end else if (start_i && !busy) begin
      busy <= 1'b1;
      cnt <= 8'h00;
      is_wr <= write_i;
      fl_addr_o <= addr_i;
      fl_dq_o <= wdata_i;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      if (sample && !is_wr)
        rdata_o <= dq_sync_i;
      if (last)
        busy <= 1'b0;
    end
  end
  assign done_o     = last;
  assign fl_dq_oe_o = busy && is_wr;
  assign fl_ce_n_o  = !strobe_on;
  assign fl_oe_n_o  = !(strobe_on && !is_wr);
  assign fl_we_n_o  = !(strobe_on && is_wr);
endmodule // flash_bus_cycle

// file: flash_device_model.sv
`timescale 1ns/100ps
module flash_device_model #(
  parameter int         BUSY_READS = 6,
  parameter int         WIN_READS  = 3,
  parameter logic [2:0] PROT_SEC   = 3'h7
) (
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  output logic [7:0]       dq_o,
  output logic [7:0]       wdata_o,
  output logic [7:0]       wcnt_o
);
  logic [7:0]  mem [0:131071];
  logic [7:0]  rbyte;
  logic [7:0]  secs;
  logic [16:0] pa;
  logic [7:0]  pd;
  logic        tgl, bad, fail, ers, susp, wr_seen;
  int          busy, win, seq;
  wire         rd_n = ce_n_i | oe_n_i;
  wire         wr_n = ce_n_i | we_n_i;
  // released bus shows the inverse of the last byte
  assign dq_o = rd_n ? ~rbyte : rbyte;
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = i[7:0];
    {rbyte, secs, pa, pd, tgl, bad, fail, ers, susp, wr_seen} = '0;
    {busy, win, seq} = '0;
    {wdata_o, wcnt_o} = '0;
  end
  always @(negedge wr_n) wr_seen = 1'b1;
  // data taken when the first of the two strobes rises
  always @(posedge wr_n) begin
    if (wr_seen) begin
      wr_seen = 1'b0;
      wcnt_o = wcnt_o + 8'h01;
      wdata_o = dq_i;
      if (dq_i == 8'hF0) begin
        {busy, win, seq} = '0;
        {fail, bad, ers, susp} = '0;
      end else if (susp && dq_i == 8'h30) begin
        susp = 1'b0;
      end else if (ers && busy > 0 && dq_i == 8'hB0) begin
        susp = 1'b1;
      end else if (ers && win > 0 && dq_i == 8'h30) begin
        secs[addr_i[16:14]] = 1'b1;
        win = WIN_READS;
        busy = WIN_READS + BUSY_READS;
      end else if (busy == 0 && !fail) begin
        case (seq)
          0: seq = (dq_i == 8'hAA) ? 1 : 0;
          1, 4: seq = (dq_i == 8'h55) ? seq + 1 : 0;
          2: seq = (dq_i == 8'hA0) ? 6 : (dq_i == 8'h80) ? 3 : 0;
          3: seq = (dq_i == 8'hAA) ? 4 : 0;
          5: begin
            seq = 0;
            if (dq_i == 8'h30) begin
              ers = 1'b1;
              secs = 8'h01 << addr_i[16:14];
              win = WIN_READS;
              busy = (addr_i[16:14] == PROT_SEC) ? 2
                                                 : win + BUSY_READS;
            end
          end
          default: begin
            seq = 0;
            pa = addr_i;
            pd = dq_i;
            bad = (mem[addr_i] & dq_i) != dq_i;
            busy = (addr_i[16:14] == PROT_SEC) ? 2 : BUSY_READS;
          end
        endcase
      end
    end
  end
  always @(negedge rd_n) begin
    // let the address launched with the strobe settle
    #1;
    if (susp && secs[addr_i[16:14]]) begin
      rbyte = {1'b1, tgl, 1'b0, 5'h00};
    end else if (!susp && (busy > 0 || fail)) begin
      tgl = ~tgl;
      rbyte = {ers ? 1'b0 : ~pd[7], tgl, fail, 1'b0,
               ers && win == 0, 3'h0};
      if (win > 0) win = win - 1;
      if (busy > 0) busy = busy - 1;
      if (busy == 0 && !fail) begin
        if (bad) fail = 1'b1;
        else if (ers) begin
          for (int s = 0; s < 8; s++)
            if (secs[s] && s[2:0] != PROT_SEC)
              for (int i = 0; i < 16384; i++)
                mem[{s[2:0], i[13:0]}] = 8'hFF;
          ers = 1'b0;
        end else if (pa[16:14] != PROT_SEC) mem[pa] = pd;
      end
    end else begin
      rbyte = mem[addr_i];
    end
  end
endmodule // flash_device_model

// file: flash_poll_params.svh
`ifndef FLASH_POLL_PARAMS_SVH
`define FLASH_POLL_PARAMS_SVH
// flash data bit positions
`define TOGGLE_BIT_POS   3
`define TIMEOUT_BIT_POS  2
`define WINDOW_BIT_POS   1
`define POLL_BIT_POS     4
`define TGL_IDX          6
`define FAIL_IDX         5
`define WIN_IDX          3
// command codes and unlock addresses
`define CMD_RESET        8'hF0
`define CMD_UNLOCK1      8'hAA
`define CMD_UNLOCK2      8'h55
`define CMD_PROGRAM      8'hA0
`define CMD_ERASE_SETUP  8'h80
`define CMD_SECTOR_ERASE 8'h30
`define ADDR_UNLOCK1     17'h0_0555
`define ADDR_UNLOCK2     17'h0_02AA
// bus timing
`define CLK_PERIOD_NS    100
`define STROBE_NS        100
`define STROBE_CYCLES    ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_GAP_US     50
`define ERASE_GAP_CYCLES ((`ERASE_GAP_US * 1000) / `CLK_PERIOD_NS)
`endif

// file: flash_poll_pkg.sv
package flash_poll_pkg;
  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_RESET
  } op_e;
  typedef enum logic [1:0] {
    RES_OK,
    RES_FAIL,
    RES_REJECTED
  } result_e;
endpackage

// file: flash_status_poller.sv
`timescale 1ns/100ps
`include "flash_poll_params.svh"
module flash_status_poller #(
  parameter int GAP_CYCLES = `ERASE_GAP_CYCLES
) (
  input  wire logic                        mclk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        req_valid_i,
  input  wire flash_poll_pkg::op_e         req_op_i,
  input  wire logic [16:0]                 req_addr_i,
  input  wire logic [7:0]                  req_data_i,
  input  wire logic                        req_more_i,
  output logic                             req_ready_o,
  output logic                             done_o,
  output flash_poll_pkg::result_e          result_o,
  output logic [7:0]                       rdata_o,
  output logic [16:0]                      fl_addr_o,
  input  wire logic [7:0]                  fl_dq_i,
  output logic [7:0]                       fl_dq_o,
  output logic                             fl_dq_oe_o,
  output logic                             fl_ce_n_o,
  output logic                             fl_oe_n_o,
  output logic                             fl_we_n_o
);
  typedef enum logic [3:0] {
    IDLE, CMD, POLL_A, POLL_B, RECHK, RESET_WR, WIN_PRE, WIN_POST, FIN
  } state_e;
  state_e     state;
  logic [7:0] dq_meta;
  logic [7:0] dq_sync;
  logic [2:0] step;
  logic [2:0] nsteps;
  logic       first_tgl;
  logic       added;
  flash_poll_pkg::op_e op;
  logic [16:0] addr;
  logic [7:0]  data;
  logic        cyc_start;
  logic        cyc_write;
  logic [16:0] cyc_addr;
  logic [7:0]  cyc_wdata;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;

  always_ff @(posedge mclk_i) begin
    dq_meta <= fl_dq_i;
    dq_sync <= dq_meta;
  end

  flash_bus_cycle u_cycle (
    .mclk_i     (mclk_i),
    .resetn_i   (resetn_i),
    .start_i    (cyc_start),
    .write_i    (cyc_write),
    .addr_i     (cyc_addr),
    .wdata_i    (cyc_wdata),
    .dq_sync_i  (dq_sync),
    .done_o     (cyc_done),
    .rdata_o    (cyc_rdata),
    .fl_addr_o  (fl_addr_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_oe_n_o  (fl_oe_n_o),
    .fl_we_n_o  (fl_we_n_o)
  );

  // command sequence table, unlock pair then opcode
  wire is_erase = (op == flash_poll_pkg::OP_SECTOR_ERASE);
  logic [16:0] seq_addr;
  logic [7:0]  seq_data;
  always_comb begin
    seq_addr = `ADDR_UNLOCK1;
    seq_data = `CMD_UNLOCK1;
    case (step)
      3'd0: begin seq_addr = `ADDR_UNLOCK1; seq_data = `CMD_UNLOCK1; end
      3'd1: begin seq_addr = `ADDR_UNLOCK2; seq_data = `CMD_UNLOCK2; end
      3'd2: begin
        seq_addr = `ADDR_UNLOCK1;
        seq_data = is_erase ? `CMD_ERASE_SETUP : `CMD_PROGRAM;
      end
      3'd3: begin
        seq_addr = is_erase ? `ADDR_UNLOCK1 : addr;
        seq_data = is_erase ? `CMD_UNLOCK1 : data;
      end
      3'd4: begin seq_addr = `ADDR_UNLOCK2; seq_data = `CMD_UNLOCK2; end
      3'd5: begin seq_addr = addr; seq_data = `CMD_SECTOR_ERASE; end
      default: begin seq_addr = addr; seq_data = data; end
    endcase
  end

  wire tgl_changed = cyc_rdata[`TGL_IDX] != first_tgl;
  wire fail_high   = cyc_rdata[`FAIL_IDX];
  wire win_closed  = cyc_rdata[`WIN_IDX];
  wire in_write    = (state == CMD) || (state == RESET_WR);
  wire in_read     = (state == POLL_A) || (state == POLL_B) ||
                     (state == RECHK) || (state == WIN_PRE) ||
                     (state == WIN_POST);
  assign cyc_start = (in_write || in_read) && !cyc_done;
  assign cyc_write = in_write;
  assign cyc_addr  = (state == CMD) ? seq_addr : addr;
  assign cyc_wdata = (state == RESET_WR) ? `CMD_RESET : seq_data;
  assign req_ready_o = (state == IDLE);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state <= IDLE;
      step <= 3'd0;
      nsteps <= 3'd0;
      first_tgl <= 1'b0;
      added <= 1'b0;
      op <= flash_poll_pkg::OP_READ;
      addr <= 17'h0_0000;
      data <= 8'h00;
      done_o <= 1'b0;
      result_o <= flash_poll_pkg::RES_OK;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      case (state)
        IDLE: if (req_valid_i) begin
          op <= req_op_i;
          addr <= req_addr_i;
          data <= req_data_i;
          added <= req_more_i && (req_op_i == flash_poll_pkg::OP_SECTOR_ERASE);
          case (req_op_i)
            flash_poll_pkg::OP_READ:  state <= FIN;
            flash_poll_pkg::OP_RESET: state <= RESET_WR;
            flash_poll_pkg::OP_PROGRAM: begin
              step <= 3'd0;
              nsteps <= 3'd3;
              state <= CMD;
            end
            default: begin
              step <= req_more_i ? 3'd5 : 3'd0;
              nsteps <= 3'd5;
              // added sector: check window before the command
              state <= req_more_i ? WIN_PRE : CMD;
            end
          endcase
        end
        WIN_PRE: if (cyc_done) begin
          if (win_closed) begin
            result_o <= flash_poll_pkg::RES_REJECTED;
            state <= FIN;
          end else
            state <= CMD;
        end
        CMD: if (cyc_done) begin
          if (step == nsteps)
            state <= added ? WIN_POST : POLL_A;
          else
            step <= step + 3'd1;
        end
        WIN_POST: if (cyc_done) begin
          // closed on the second check: last command maybe lost
          result_o <= win_closed ? flash_poll_pkg::RES_REJECTED
                                 : flash_poll_pkg::RES_OK;
          state <= FIN;
        end
        POLL_A: if (cyc_done) begin
          first_tgl <= cyc_rdata[`TGL_IDX];
          state <= POLL_B;
        end
        POLL_B: if (cyc_done) begin
          if (!tgl_changed) begin
            result_o <= flash_poll_pkg::RES_OK;
            state <= FIN;
          end else if (fail_high) begin
            first_tgl <= cyc_rdata[`TGL_IDX];
            state <= RECHK;
          end else
            first_tgl <= cyc_rdata[`TGL_IDX];
        end
        RECHK: if (cyc_done) begin
          if (tgl_changed) begin
            result_o <= flash_poll_pkg::RES_FAIL;
            state <= RESET_WR;
          end else begin
            result_o <= flash_poll_pkg::RES_OK;
            state <= FIN;
          end
        end
        RESET_WR: if (cyc_done) begin
          if (op == flash_poll_pkg::OP_RESET)
            result_o <= flash_poll_pkg::RES_OK;
          state <= FIN;
        end
        FIN: begin
          if (op == flash_poll_pkg::OP_READ)
            state <= POLL_B;
          else begin
            done_o <= 1'b1;
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
      // plain read: one bus read, data returned as is
      if (state == POLL_B && op == flash_poll_pkg::OP_READ && cyc_done) begin
        rdata_o <= cyc_rdata;
        result_o <= flash_poll_pkg::RES_OK;
        done_o <= 1'b1;
        state <= IDLE;
      end else if (cyc_done && state != RESET_WR)
        rdata_o <= cyc_rdata;
    end
  end

  property p_ready_idle;
    @(posedge mclk_i) disable iff (!resetn_i)
      done_o |=> req_ready_o;
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("not ready after done");
  property p_fail_reset;
    @(posedge mclk_i) disable iff (!resetn_i)
      (state == RECHK && cyc_done && tgl_changed) |=> state == RESET_WR;
  endproperty
  a_fail_reset: assert property (p_fail_reset)
    else $error("no reset after failure");
  property p_reset_code;
    @(posedge mclk_i) disable iff (!resetn_i)
      (state == RESET_WR && cyc_start) |=> fl_dq_o == `CMD_RESET;
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("reset write code wrong");
  property p_stable_done;
    @(posedge mclk_i) disable iff (!resetn_i)
      (state == POLL_B && op != flash_poll_pkg::OP_READ && cyc_done
       && !tgl_changed) |=> state == FIN;
  endproperty
  a_stable_done: assert property (p_stable_done)
    else $error("stable toggle not treated as done");
  property p_rechk;
    @(posedge mclk_i) disable iff (!resetn_i)
      (state == POLL_B && op != flash_poll_pkg::OP_READ && cyc_done
       && tgl_changed && fail_high) |=> state == RECHK;
  endproperty
  a_rechk: assert property (p_rechk)
    else $error("timeout not rechecked");
  property p_win_rej;
    @(posedge mclk_i) disable iff (!resetn_i)
      (state == WIN_POST && cyc_done && win_closed)
        |=> result_o == flash_poll_pkg::RES_REJECTED;
  endproperty
  a_win_rej: assert property (p_win_rej)
    else $error("closed window not reported");
  property p_no_cmd_closed;
    @(posedge mclk_i) disable iff (!resetn_i)
      (state == WIN_PRE && cyc_done && win_closed) |=> state != CMD;
  endproperty
  a_no_cmd_closed: assert property (p_no_cmd_closed)
    else $error("command sent into closed window");
  property p_strobe_excl;
    @(posedge mclk_i) disable iff (!resetn_i)
      !(!fl_oe_n_o && !fl_we_n_o) && !(fl_dq_oe_o && !fl_oe_n_o);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("read and write strobes overlap");
  c_fail: cover property (@(posedge mclk_i)
    state == RECHK ##[1:40] state == RESET_WR);
  c_ok: cover property (@(posedge mclk_i)
    done_o && result_o == flash_poll_pkg::RES_OK);
  c_rej: cover property (@(posedge mclk_i)
    done_o && result_o == flash_poll_pkg::RES_REJECTED);
endmodule // flash_status_poller

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  logic                    mclk_i, resetn_i, req_valid, req_more;
  flash_poll_pkg::op_e     req_op;
  logic [16:0]             req_addr, fl_addr;
  logic [7:0]              req_data, rdata, fl_dq_o, dev_dq, wdata, wcnt;
  logic [7:0]              wb, rd;
  logic                    req_ready, done, fl_dq_oe, ce_n, oe_n, we_n;
  flash_poll_pkg::result_e result, res;
  int                      err_total, tests_run;
  wire logic [7:0]         fl_dq_i = fl_dq_oe ? fl_dq_o : dev_dq;

  flash_status_poller #(.GAP_CYCLES(50)) uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .req_valid_i(req_valid),
    .req_op_i(req_op), .req_addr_i(req_addr), .req_data_i(req_data),
    .req_more_i(req_more), .req_ready_o(req_ready), .done_o(done),
    .result_o(result), .rdata_o(rdata), .fl_addr_o(fl_addr),
    .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe),
    .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n));
  flash_device_model dev (
    .addr_i(fl_addr), .dq_i(fl_dq_i), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .dq_o(dev_dq), .wdata_o(wdata), .wcnt_o(wcnt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run(input flash_poll_pkg::op_e o, input logic [16:0] a,
                     input logic [7:0] d, input logic m);
    int n;
    wb = wcnt;
    @(posedge mclk_i);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_data <= d;
    req_more <= m;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (req_ready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    @(posedge mclk_i);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (done !== 1'b1 && n < 20000);
    if (done !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    res = result;
    rd = rdata;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    {resetn_i, req_valid, req_more, req_addr, req_data} = '0;
    req_op = flash_poll_pkg::OP_READ;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    run(flash_poll_pkg::OP_READ, 17'h0_0123, 8'h00, 1'b0);
    chk(rd, 8'h23);
    $display("array read done");
    run(flash_poll_pkg::OP_PROGRAM, 17'h0_0123, 8'h21, 1'b0);
    chk(res, flash_poll_pkg::RES_OK);
    chk(wcnt - wb, 8'h04);
    run(flash_poll_pkg::OP_READ, 17'h0_0123, 8'h00, 1'b0);
    chk(rd, 8'h21);
    $display("program done");
    run(flash_poll_pkg::OP_PROGRAM, 17'h0_0123, 8'hFF, 1'b0);
    chk(res, flash_poll_pkg::RES_FAIL);
    chk(wdata, 8'hF0);
    chk(wcnt - wb, 8'h05);
    run(flash_poll_pkg::OP_READ, 17'h0_0123, 8'h00, 1'b0);
    chk(rd, 8'h21);
    $display("program failure done");
    run(flash_poll_pkg::OP_PROGRAM, 17'h1_C010, 8'h00, 1'b0);
    chk(res, flash_poll_pkg::RES_OK);
    run(flash_poll_pkg::OP_READ, 17'h1_C010, 8'h00, 1'b0);
    chk(rd, 8'h10);
    $display("protected program done");
    run(flash_poll_pkg::OP_SECTOR_ERASE, 17'h0_4005, 8'h00, 1'b0);
    chk(res, flash_poll_pkg::RES_OK);
    chk(wcnt - wb, 8'h06);
    run(flash_poll_pkg::OP_READ, 17'h0_4005, 8'h00, 1'b0);
    chk(rd, 8'hFF);
    run(flash_poll_pkg::OP_READ, 17'h0_0123, 8'h00, 1'b0);
    chk(rd, 8'h21);
    $display("sector erase done");
    run(flash_poll_pkg::OP_SECTOR_ERASE, 17'h1_C010, 8'h00, 1'b0);
    chk(res, flash_poll_pkg::RES_OK);
    run(flash_poll_pkg::OP_READ, 17'h1_C010, 8'h00, 1'b0);
    chk(rd, 8'h10);
    $display("protected erase done");
    run(flash_poll_pkg::OP_SECTOR_ERASE, 17'h0_0008, 8'h00, 1'b1);
    chk(res, flash_poll_pkg::RES_REJECTED);
    chk(wcnt - wb, 8'h00);
    run(flash_poll_pkg::OP_SECTOR_ERASE, 17'h0_0004, 8'h00, 1'b1);
    chk(res, flash_poll_pkg::RES_OK);
    chk(wdata, 8'h30);
    $display("added sector done");
    run(flash_poll_pkg::OP_RESET, 17'h0_0000, 8'h00, 1'b0);
    chk(wdata, 8'hF0);
    chk(wcnt - wb, 8'h01);
    $display("reset command done");
    report_and_stop();
  end
endmodule // testbench
